// [rtl/dt_pkg.sv]
/*
  Shared constants for the dual 32-bit timer: register offsets, field
  positions, mode and enable encodings.
  Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
package dt_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam int DT_ADDR_W = 5;
  localparam logic [4:0] DT_OFS_LO_CNT = 5'h00;
  localparam logic [4:0] DT_OFS_HI_CNT = 5'h04;
  localparam logic [4:0] DT_OFS_LO_PRD = 5'h08;
  localparam logic [4:0] DT_OFS_HI_PRD = 5'h0C;
  localparam logic [4:0] DT_OFS_TCR = 5'h10;
  localparam logic [4:0] DT_OFS_GCR = 5'h14;
  localparam logic [4:0] DT_OFS_STAT = 5'h18;

  // ----------------------------------------------------------------
  // timer_control_reg fields
  // ----------------------------------------------------------------
  localparam int DT_TCR_LO_ENA_LSB = 6;
  localparam int DT_TCR_CLK_SEL = 8;
  localparam int DT_TCR_HI_ENA_LSB = 22;

  // ----------------------------------------------------------------
  // global_control_reg fields
  // ----------------------------------------------------------------
  localparam int DT_GCR_LO_OOR = 0;
  localparam int DT_GCR_HI_OOR = 1;
  localparam int DT_GCR_MODE_LSB = 2;
  localparam int DT_GCR_NIB_PRD_LSB = 8;
  localparam int DT_GCR_NIB_CNT_LSB = 12;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] DT_MODE_UNCHAINED = 2'h1;
  localparam logic [1:0] DT_MODE_CHAINED = 2'h3;

  typedef enum logic [1:0] {
    DT_ENA_OFF = 2'h0,
    DT_ENA_ONCE = 2'h1,
    DT_ENA_CONT = 2'h2
  } dt_ena_t;

endpackage

// [rtl/dt_ext_sync.sv]
/*
  Synchroniser for the external count clock: three flip-flops, and an
  edge counts once the second and third agree. Emits a one-cycle pulse
  per accepted rising edge.
  Assumes the external clock is slow against clk_in.
*/
`timescale 1ns/1ps
module dt_ext_sync (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ext_clock_in,
  output logic rise_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic s1;    // First stage, read only by s2
    logic s2;
    logic s3;
    logic level; // Accepted level
    logic rise;  // Accepted rising edge
  } dt_sync_t;

  dt_sync_t st_r;
  dt_sync_t st_nxt;

  // Shift and agree-filter
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = ext_clock_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.rise = 1'b0;
    // Glitch shorter than a cycle never agrees
    if (st_r.s2 == st_r.s3) begin
      st_nxt.level = st_r.s3;
      st_nxt.rise = st_r.s3 && !st_r.level;
    end
  end

  // Registers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise_out = st_r.rise;

endmodule // dt_ext_sync

// [rtl/dt_timer.sv]
/*
  Dual 32-bit timer, chained and unchained modes, with an Avalon-MM
  register slave and event pulses for the interrupt and DMA controllers.
  Assumes one clock; the external count clock is synchronised here and
  is far slower than clk_in.
*/
// Behaviour
// - Mode 3h chains high prescaler into low
// - Mode 1 gives two independent timers
// - Chained prescaler wraps, ticks after period match
// - Chained low timer advances on prescaler ticks
// - Counter equals period raises irq and dma
// - Continuous counter clears after period match
// - Upper control half ignored when chained
// - Per-half out-of-reset bits; chained needs both
// - Chained: only low enable mode matters
// - Enable mode: stop, once, continuous
// - Nibble prescaler always on internal clock
// - Nibble prescaler ticks after period match
// - Unchained high timer advances per nibble tick
// - High half uses only its bits
// - Unchained low half counts every input clock
// - Unchained halves run independently
// - External clock feeds only low side: low half, or chained prescaler
// - External count synchronised to internal clock
// - Zero count and period never increments
// - Clearing one reset bit resets that half
// - Held half keeps its counter value
// - clock_select picks low half clock source
// - Active timer blocks writes except enables, resets
`timescale 1ns/1ps
module dt_timer (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ext_clock_in,
  input wire logic [4:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  output logic timer_irq_low_out,
  output logic timer_irq_high_out,
  output logic timer_dma_event_low_out,
  output logic timer_dma_event_high_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] lo_cnt;  // low_counter
    logic [31:0] hi_cnt;  // high_counter
    logic [31:0] lo_prd;  // low_period
    logic [31:0] hi_prd;  // high_period
    logic [1:0] lo_ena;   // low_enable_mode
    logic [1:0] hi_ena;   // high_enable_mode
    logic clk_sel;        // clock_select
    logic lo_oor;         // low_side_out_of_reset
    logic hi_oor;         // high_side_out_of_reset
    logic [1:0] mode;     // timer_mode_field
    logic [3:0] nib_cnt;  // nibble_prescale_count
    logic [3:0] nib_prd;  // nibble_prescale_period
    logic lo_done;        // One-shot finished, low
    logic hi_done;        // One-shot finished, high
    logic wait_r;         // Bus waitrequest
    logic [31:0] rdata;   // Bus read data
    logic lo_irq;
    logic hi_irq;
    logic lo_dma;
    logic hi_dma;
  } dt_state_t;

  dt_state_t st_r;
  dt_state_t st_nxt;

  logic ext_tick;   // Synchronised external edge
  logic chained;
  logic unchained;
  logic lo_run;     // Low half (or whole chain) counting
  logic hi_run;     // Unchained high half counting
  logic in_step;    // One input clock for the low side
  logic any_act;    // Low half, or unchained high half, enabled and out of reset
  logic wr_acc;     // Write accepted this edge
  logic rd_take;    // Read data latched this edge
  logic pre_tick;   // Chained prescaler tick
  logic nib_tick;   // Nibble prescaler tick
  logic lo_step;
  logic [33:0] lo_adv;
  logic [33:0] hi_adv;

  // ----------------------------------------------------------------
  // External clock synchroniser
  // ----------------------------------------------------------------
  dt_ext_sync u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ext_clock_in(ext_clock_in),
    .rise_out(ext_tick)
  );

  // ----------------------------------------------------------------
  // Timer advance: returns {next count, one-shot done, match}
  // ----------------------------------------------------------------
  function automatic logic [33:0] tmr_adv(input logic [31:0] cnt,
                                          input logic [31:0] prd,
                                          input logic [1:0] ena);
    logic [31:0] n;
    n = cnt;
    if (cnt == 32'h0 && prd == 32'h0) begin
      n = cnt;
    end else if (cnt == prd) begin
      n = 32'h0;
    end else begin
      n = cnt + 32'h1; // Overflow rolls over to zero
    end
    tmr_adv = {n, (n == prd) && (n != cnt) && (ena == dt_pkg::DT_ENA_ONCE),
               (n == prd) && (n != cnt)};
  endfunction

  // ----------------------------------------------------------------
  // Mode and run decode
  // ----------------------------------------------------------------
  assign chained = (st_r.mode == dt_pkg::DT_MODE_CHAINED);
  assign unchained = (st_r.mode == dt_pkg::DT_MODE_UNCHAINED);
  // Chained needs both halves out of reset; only low enable counts
  assign lo_run = st_r.lo_oor && (st_r.lo_ena != dt_pkg::DT_ENA_OFF) && !st_r.lo_done
                  && (unchained || (chained && st_r.hi_oor));
  // High half looks at its own bits only
  assign hi_run = unchained && st_r.hi_oor && (st_r.hi_ena != dt_pkg::DT_ENA_OFF)
                  && !st_r.hi_done;
  // Low side input clock: internal every cycle, or external edge
  assign in_step = st_r.clk_sel ? ext_tick : 1'b1;
  assign any_act = (st_r.lo_oor && st_r.lo_ena != dt_pkg::DT_ENA_OFF)
                   || (unchained && st_r.hi_oor && st_r.hi_ena != dt_pkg::DT_ENA_OFF);
  assign wr_acc = write_in && !st_r.wait_r;
  assign rd_take = read_in && st_r.wait_r;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    pre_tick = 1'b0;
    nib_tick = 1'b0;
    lo_step = 1'b0;
    lo_adv = '0;
    hi_adv = '0;
    // Event outputs are single-cycle pulses
    st_nxt.lo_irq = 1'b0;
    st_nxt.hi_irq = 1'b0;
    st_nxt.lo_dma = 1'b0;
    st_nxt.hi_dma = 1'b0;

    // Chained: high_counter is a 32-bit prescaler
    if (chained && lo_run && in_step) begin
      if (st_r.hi_cnt == st_r.hi_prd) begin
        st_nxt.hi_cnt = 32'h0;
        pre_tick = 1'b1;
      end else begin
        st_nxt.hi_cnt = st_r.hi_cnt + 32'h1;
      end
    end

    // Unchained: nibble prescaler, internal clock only
    if (hi_run) begin
      if (st_r.nib_cnt == st_r.nib_prd) begin
        st_nxt.nib_cnt = 4'h0;
        nib_tick = 1'b1;
      end else begin
        st_nxt.nib_cnt = st_r.nib_cnt + 4'h1;
      end
    end

    // Low timer: prescaler ticks when chained, input clock otherwise
    lo_step = chained ? pre_tick : (unchained && lo_run && in_step);
    if (lo_step) begin
      lo_adv = tmr_adv(st_r.lo_cnt, st_r.lo_prd, st_r.lo_ena);
      st_nxt.lo_cnt = lo_adv[33:2];
      st_nxt.lo_done = lo_adv[1];
      st_nxt.lo_irq = lo_adv[0];
      st_nxt.lo_dma = lo_adv[0];
    end

    // Unchained high timer, one step per nibble tick
    if (nib_tick) begin
      hi_adv = tmr_adv(st_r.hi_cnt, st_r.hi_prd, st_r.hi_ena);
      st_nxt.hi_cnt = hi_adv[33:2];
      st_nxt.hi_done = hi_adv[1];
      st_nxt.hi_irq = hi_adv[0];
      st_nxt.hi_dma = hi_adv[0];
    end

    // Bus handshake: one wait cycle, then one ready cycle
    st_nxt.wait_r = !((read_in || write_in) && st_r.wait_r);

    // Read data latched on the wait cycle, stands for the ready cycle
    if (rd_take) begin
      if (address_in == dt_pkg::DT_OFS_LO_CNT) begin
        st_nxt.rdata = st_r.lo_cnt;
      end else if (address_in == dt_pkg::DT_OFS_HI_CNT) begin
        st_nxt.rdata = st_r.hi_cnt;
      end else if (address_in == dt_pkg::DT_OFS_LO_PRD) begin
        st_nxt.rdata = st_r.lo_prd;
      end else if (address_in == dt_pkg::DT_OFS_HI_PRD) begin
        st_nxt.rdata = st_r.hi_prd;
      end else if (address_in == dt_pkg::DT_OFS_TCR) begin
        st_nxt.rdata = '0;
        st_nxt.rdata[dt_pkg::DT_TCR_LO_ENA_LSB +: 2] = st_r.lo_ena;
        st_nxt.rdata[dt_pkg::DT_TCR_CLK_SEL] = st_r.clk_sel;
        st_nxt.rdata[dt_pkg::DT_TCR_HI_ENA_LSB +: 2] = st_r.hi_ena;
      end else if (address_in == dt_pkg::DT_OFS_GCR) begin
        st_nxt.rdata = '0;
        st_nxt.rdata[dt_pkg::DT_GCR_LO_OOR] = st_r.lo_oor;
        st_nxt.rdata[dt_pkg::DT_GCR_HI_OOR] = st_r.hi_oor;
        st_nxt.rdata[dt_pkg::DT_GCR_MODE_LSB +: 2] = st_r.mode;
        st_nxt.rdata[dt_pkg::DT_GCR_NIB_PRD_LSB +: 4] = st_r.nib_prd;
        st_nxt.rdata[dt_pkg::DT_GCR_NIB_CNT_LSB +: 4] = st_r.nib_cnt;
      end else if (address_in == dt_pkg::DT_OFS_STAT) begin
        // Live status: run and one-shot done per half
        st_nxt.rdata = {28'h0, st_r.hi_done, st_r.lo_done, hi_run, lo_run};
      end else begin
        st_nxt.rdata = '0; // Unmapped reads as zero
      end
    end

    // Writes; an active timer accepts only enables and reset bits
    if (wr_acc) begin
      if (address_in == dt_pkg::DT_OFS_LO_CNT) begin
        if (!any_act) begin
          st_nxt.lo_cnt = writedata_in;
        end
      end else if (address_in == dt_pkg::DT_OFS_HI_CNT) begin
        if (!any_act) begin
          st_nxt.hi_cnt = writedata_in;
        end
      end else if (address_in == dt_pkg::DT_OFS_LO_PRD) begin
        if (!any_act) begin
          st_nxt.lo_prd = writedata_in;
        end
      end else if (address_in == dt_pkg::DT_OFS_HI_PRD) begin
        if (!any_act) begin
          st_nxt.hi_prd = writedata_in;
        end
      end else if (address_in == dt_pkg::DT_OFS_TCR) begin
        // Enable write re-arms one-shot halves
        st_nxt.lo_ena = writedata_in[dt_pkg::DT_TCR_LO_ENA_LSB +: 2];
        st_nxt.hi_ena = writedata_in[dt_pkg::DT_TCR_HI_ENA_LSB +: 2];
        // A one-shot finishing on this very edge keeps its done flag
        st_nxt.lo_done = lo_adv[1];
        st_nxt.hi_done = hi_adv[1];
        if (!any_act) begin
          st_nxt.clk_sel = writedata_in[dt_pkg::DT_TCR_CLK_SEL];
        end
      end else if (address_in == dt_pkg::DT_OFS_GCR) begin
        st_nxt.lo_oor = writedata_in[dt_pkg::DT_GCR_LO_OOR];
        st_nxt.hi_oor = writedata_in[dt_pkg::DT_GCR_HI_OOR];
        if (!any_act) begin
          st_nxt.mode = writedata_in[dt_pkg::DT_GCR_MODE_LSB +: 2];
          st_nxt.nib_prd = writedata_in[dt_pkg::DT_GCR_NIB_PRD_LSB +: 4];
          st_nxt.nib_cnt = writedata_in[dt_pkg::DT_GCR_NIB_CNT_LSB +: 4];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register; held halves keep their counts (no clear)
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
      st_r.wait_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign readdata_out = st_r.rdata;
  assign waitrequest_out = st_r.wait_r;
  assign timer_irq_low_out = st_r.lo_irq;
  assign timer_irq_high_out = st_r.hi_irq;
  assign timer_dma_event_low_out = st_r.lo_dma;
  assign timer_dma_event_high_out = st_r.hi_dma;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Bus answers one cycle after the request is seen
  bus_answer_a: assert property ((read_in || write_in) && waitrequest_out
                                 |=> !waitrequest_out ##1 waitrequest_out)
    else $error("waitrequest did not drop for one cycle");

  chain_tick_a: assert property (chained && lo_run && in_step && st_r.hi_cnt == st_r.hi_prd
                                 && st_r.lo_prd != 32'h0
                                 |=> st_r.hi_cnt == 32'h0 && st_r.lo_cnt != $past(st_r.lo_cnt))
    else $error("chained prescaler did not tick and clear");

  chain_hold_a: assert property (chained && lo_run && !pre_tick
                                 |=> $stable(st_r.lo_cnt))
    else $error("low timer moved without a prescaler tick");

  irq_match_a: assert property (timer_irq_low_out |-> st_r.lo_cnt == st_r.lo_prd
                                && timer_dma_event_low_out)
    else $error("low event without period match");

  cont_wrap_a: assert property (lo_step && st_r.lo_ena == dt_pkg::DT_ENA_CONT
                                && st_r.lo_cnt == st_r.lo_prd && st_r.lo_prd != 32'h0
                                |=> st_r.lo_cnt == 32'h0)
    else $error("continuous counter did not clear");

  chained_hi_a: assert property (chained |=> !timer_irq_high_out)
    else $error("high event in chained mode");

  nib_tick_a: assert property (hi_run && st_r.nib_cnt == st_r.nib_prd
                               |=> st_r.nib_cnt == 4'h0)
    else $error("nibble prescaler did not clear on tick");

  reset_hold_a: assert property (!st_r.lo_oor && !wr_acc |=> $stable(st_r.lo_cnt))
    else $error("low counter changed while held in reset");

  zero_stuck_a: assert property (st_r.lo_cnt == 32'h0 && st_r.lo_prd == 32'h0 && !wr_acc
                                 |=> st_r.lo_cnt == 32'h0)
    else $error("zero counter with zero period moved");

  oneshot_stop_a: assert property (st_r.lo_done && !wr_acc
                                   |=> $stable(st_r.lo_cnt) && !timer_irq_low_out)
    else $error("one-shot low half kept counting");

  protect_a: assert property (any_act && wr_acc && address_in == dt_pkg::DT_OFS_LO_PRD
                              |=> $stable(st_r.lo_prd))
    else $error("period written while timer active");

  chain_tick_c: cover property (chained && pre_tick);
  oneshot_c: cover property (lo_step && lo_adv[1]);
  ext_count_c: cover property (st_r.clk_sel && ext_tick && lo_step);
  nib_event_c: cover property (timer_irq_high_out);

endmodule // dt_timer

// [verif/dt_event_sink.sv]
/*
  Event sink for the interrupt and DMA controllers at the timer's far side.
  It counts event pulses, stamps the gap between them, and flags any cycle
  where an interrupt pulse and its DMA pulse disagree.
  Assumes the timer's event pulses are registered on clk_in and last one cycle.
*/
`timescale 1ns/1ps
module dt_event_sink (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic irq_low_in,
  input wire logic irq_high_in,
  input wire logic dma_low_in,
  input wire logic dma_high_in,
  output logic [15:0] count_low_out,
  output logic [15:0] count_high_out,
  output logic [31:0] gap_low_out,
  output logic [31:0] gap_high_out,
  output logic pair_err_out
);
  // ----------------------------------------------------------------
  // Cycle stamps
  // ----------------------------------------------------------------
  logic [31:0] now_r; // Free-running cycle count
  logic [31:0] last_low_r; // Stamp of the last low event
  logic [31:0] last_high_r; // Stamp of the last high event

  // Count events and measure spacing; the first gap after a change is stale
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      now_r <= 32'h0;
      last_low_r <= 32'h0;
      last_high_r <= 32'h0;
      count_low_out <= 16'h0;
      count_high_out <= 16'h0;
      gap_low_out <= 32'h0;
      gap_high_out <= 32'h0;
      pair_err_out <= 1'b0;
    end else begin
      now_r <= now_r + 32'h1;
      if (irq_low_in) begin
        count_low_out <= count_low_out + 16'h1;
        gap_low_out <= now_r - last_low_r;
        last_low_r <= now_r;
      end
      if (irq_high_in) begin
        count_high_out <= count_high_out + 16'h1;
        gap_high_out <= now_r - last_high_r;
        last_high_r <= now_r;
      end
      // Sticky: the controllers expect both pulses on the same cycle
      if (irq_low_in !== dma_low_in || irq_high_in !== dma_high_in) begin
        pair_err_out <= 1'b1;
      end
    end
  end
endmodule // dt_event_sink

// [verif/testbench.sv]
/*
  Self-checking bench for the dual 32-bit timer: Avalon-MM master tasks,
  a read monitor fed by a queue of notes, and an event sink model.
  Assumes the register map and field positions of dt_pkg.
*/
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ext_clock_in = 1'b0;
  logic [4:0] address_in = 5'h00;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic [31:0] readdata_out;
  logic waitrequest_out, irq_lo, irq_hi, dma_lo, dma_hi, pair_err;
  logic [15:0] cnt_lo, cnt_hi;
  logic [31:0] gap_lo, gap_hi;
  logic [31:0] expect_q[$]; // Notes of expected read data
  int miscompares = 0;
  int n_compared = 0;
  int seed = 32'hce4a;
  logic ext_run = 1'b0; // External clock only toggles inside its scenario
  int ext_div = 0;

  always #2.5 clk_in = ~clk_in;

  dt_timer i_dt_timer (.clk_in(clk_in), .reset_n_in(reset_n_in), .ext_clock_in(ext_clock_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .timer_irq_low_out(irq_lo),
    .timer_irq_high_out(irq_hi), .timer_dma_event_low_out(dma_lo), .timer_dma_event_high_out(dma_hi));
  dt_event_sink i_dt_event_sink (.clk_in(clk_in), .reset_n_in(reset_n_in), .irq_low_in(irq_lo),
    .irq_high_in(irq_hi), .dma_low_in(dma_lo), .dma_high_in(dma_hi), .count_low_out(cnt_lo),
    .count_high_out(cnt_hi), .gap_low_out(gap_lo), .gap_high_out(gap_hi), .pair_err_out(pair_err));

  // External count clock: period of 10 clk_in cycles, well under the sync limit
  always @(posedge clk_in) begin
    if (ext_run) begin
      ext_div <= (ext_div == 4) ? 0 : ext_div + 1;
      if (ext_div == 4) begin
        ext_clock_in <= ~ext_clock_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Monitor: read data stand in the one cycle waitrequest is low
  always @(negedge clk_in) begin
    if (read_in && waitrequest_out === 1'b0) begin
      if (expect_q.size() == 0) begin
        chk(readdata_out, 32'hFFFFFFFF, "read without note");
      end else begin
        chk(readdata_out, expect_q.pop_front(), "read data");
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus master tasks
  // ----------------------------------------------------------------
  // Holds the request until the edge that samples waitrequest low
  task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    address_in <= a;
    write_in <= wr;
    read_in <= ~wr;
    writedata_in <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 100);
    write_in <= 1'b0;
    read_in <= 1'b0;
    chk(32'(n < 100), 32'h1, "bus answer");
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    expect_q.push_back(exp);
    bus(a, 1'b0, 32'h0);
  endtask

  function automatic logic [31:0] gcr(input logic lo, input logic hi, input logic [1:0] md, input logic [3:0] np);
    gcr = (32'(lo) << dt_pkg::DT_GCR_LO_OOR) | (32'(hi) << dt_pkg::DT_GCR_HI_OOR)
        | (32'(md) << dt_pkg::DT_GCR_MODE_LSB) | (32'(np) << dt_pkg::DT_GCR_NIB_PRD_LSB);
  endfunction

  function automatic logic [31:0] timer_control_reg(input dt_pkg::dt_ena_t le, input logic cs, input dt_pkg::dt_ena_t he);
    timer_control_reg = (32'(le) << dt_pkg::DT_TCR_LO_ENA_LSB) | (32'(cs) << dt_pkg::DT_TCR_CLK_SEL)
        | (32'(he) << dt_pkg::DT_TCR_HI_ENA_LSB);
  endfunction

  // Stop first, since a running timer drops configuration writes
  task automatic cfg(input logic [31:0] g, input logic [31:0] lc, input logic [31:0] hc,
                     input logic [31:0] lp, input logic [31:0] hp);
    wr(dt_pkg::DT_OFS_TCR, 32'h0);
    wr(dt_pkg::DT_OFS_GCR, g);
    wr(dt_pkg::DT_OFS_LO_CNT, lc);
    wr(dt_pkg::DT_OFS_HI_CNT, hc);
    wr(dt_pkg::DT_OFS_LO_PRD, lp);
    wr(dt_pkg::DT_OFS_HI_PRD, hp);
  endtask

  // Bounded wait for n more events on one side
  task automatic wait_ev(input logic hi, input int n);
    int base, k;
    base = hi ? int'(cnt_hi) : int'(cnt_lo);
    k = 0;
    while ((hi ? int'(cnt_hi) : int'(cnt_lo)) - base < n && k < 4000) begin
      @(posedge clk_in);
      k++;
    end
    chk(32'(k < 4000), 32'h1, "event wait");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int p, np, h, a, b;
    logic [15:0] c0;
    p = 3 + ($random(seed) & 7);
    np = 1 + ($random(seed) & 3);
    h = 2 + ($random(seed) & 3);
    a = 1 + ($random(seed) & 3);
    b = 1 + ($random(seed) & 3);
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    // All registers clear after reset; 0x1C is a hole
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0);
    // Both unchained halves running at once
    cfg(gcr(1'b1, 1'b1, dt_pkg::DT_MODE_UNCHAINED, 4'(np)), 32'h0, 32'h0, 32'(p), 32'(h));
    wr(dt_pkg::DT_OFS_TCR, timer_control_reg(dt_pkg::DT_ENA_CONT, 1'b0, dt_pkg::DT_ENA_CONT));
    wait_ev(1'b0, 3);
    chk(gap_lo, 32'(p + 1), "low gap");
    wait_ev(1'b1, 3);
    chk(gap_hi, 32'((np + 1) * (h + 1)), "high gap");
    wr(dt_pkg::DT_OFS_LO_PRD, 32'(p + 5));
    // Put only the low half into reset
    wr(dt_pkg::DT_OFS_GCR, gcr(1'b0, 1'b1, dt_pkg::DT_MODE_UNCHAINED, 4'(np)));
    repeat (3) @(posedge clk_in);
    c0 = cnt_lo;
    wait_ev(1'b1, 2);
    chk(gap_hi, 32'((np + 1) * (h + 1)), "high gap alone");
    chk(32'(cnt_lo), 32'(c0), "low held quiet");
    wr(dt_pkg::DT_OFS_TCR, 32'h0);
    rd(dt_pkg::DT_OFS_LO_PRD, 32'(p));
    // Held in reset or disabled, a counter keeps its value
    cfg(gcr(1'b0, 1'b1, dt_pkg::DT_MODE_UNCHAINED, 4'h0), 32'h7, 32'h0, 32'h9, 32'h0);
    wr(dt_pkg::DT_OFS_TCR, timer_control_reg(dt_pkg::DT_ENA_CONT, 1'b0, dt_pkg::DT_ENA_OFF));
    repeat (20) @(posedge clk_in);
    rd(dt_pkg::DT_OFS_LO_CNT, 32'h7);
    wr(dt_pkg::DT_OFS_TCR, 32'h0);
    wr(dt_pkg::DT_OFS_GCR, gcr(1'b1, 1'b1, dt_pkg::DT_MODE_UNCHAINED, 4'h0));
    repeat (20) @(posedge clk_in);
    rd(dt_pkg::DT_OFS_LO_CNT, 32'h7);
    rd(dt_pkg::DT_OFS_HI_CNT, 32'h0);
    // One-shot low half stops at its period
    cfg(gcr(1'b1, 1'b0, dt_pkg::DT_MODE_UNCHAINED, 4'h0), 32'h0, 32'h0, 32'(p), 32'h0);
    c0 = cnt_lo;
    wr(dt_pkg::DT_OFS_TCR, timer_control_reg(dt_pkg::DT_ENA_ONCE, 1'b0, dt_pkg::DT_ENA_OFF));
    wait_ev(1'b0, 1);
    repeat (3 * p + 12) @(posedge clk_in);
    chk(32'(cnt_lo - c0), 32'h1, "one-shot events");
    rd(dt_pkg::DT_OFS_LO_CNT, 32'(p));
    // Chained pair; high enable left off must not matter
    cfg(gcr(1'b1, 1'b1, dt_pkg::DT_MODE_CHAINED, 4'h0), 32'h0, 32'h0, 32'(b), 32'(a));
    c0 = cnt_hi;
    wr(dt_pkg::DT_OFS_TCR, timer_control_reg(dt_pkg::DT_ENA_CONT, 1'b0, dt_pkg::DT_ENA_OFF));
    wait_ev(1'b0, 3);
    chk(gap_lo, 32'((a + 1) * (b + 1)), "chained gap");
    chk(32'(cnt_hi), 32'(c0), "no high events");
    // Zero count and zero period never move
    cfg(gcr(1'b1, 1'b1, dt_pkg::DT_MODE_UNCHAINED, 4'h0), 32'h0, 32'h0, 32'h0, 32'h0);
    c0 = cnt_lo;
    wr(dt_pkg::DT_OFS_TCR, timer_control_reg(dt_pkg::DT_ENA_CONT, 1'b0, dt_pkg::DT_ENA_CONT));
    repeat (40) @(posedge clk_in);
    chk(32'(cnt_lo), 32'(c0), "zero timer events");
    rd(dt_pkg::DT_OFS_LO_CNT, 32'h0);
    rd(dt_pkg::DT_OFS_HI_CNT, 32'h0);
    // Low half on the external clock, high half stays internal
    cfg(gcr(1'b1, 1'b1, dt_pkg::DT_MODE_UNCHAINED, 4'(np)), 32'h0, 32'h0, 32'(p), 32'(h));
    ext_run <= 1'b1;
    wr(dt_pkg::DT_OFS_TCR, timer_control_reg(dt_pkg::DT_ENA_CONT, 1'b1, dt_pkg::DT_ENA_CONT));
    wait_ev(1'b0, 3);
    chk(gap_lo, 32'((p + 1) * 10), "ext gap");
    wait_ev(1'b1, 2);
    chk(gap_hi, 32'((np + 1) * (h + 1)), "high gap ext");
    wr(dt_pkg::DT_OFS_TCR, timer_control_reg(dt_pkg::DT_ENA_OFF, 1'b1, dt_pkg::DT_ENA_CONT));
    repeat (20) @(posedge clk_in);
    wr(dt_pkg::DT_OFS_TCR, timer_control_reg(dt_pkg::DT_ENA_CONT, 1'b1, dt_pkg::DT_ENA_CONT));
    wait_ev(1'b0, 3);
    chk(gap_lo, 32'((p + 1) * 10), "ext restart gap");
    ext_run <= 1'b0;
    chk(32'(pair_err), 32'h0, "irq and dma paired");
    conclude();
  end

  // Watchdog: the scenarios need well under two thousand cycles; allow forty thousand
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule // testbench
